// ===== gpx_pkg.sv
package gpx_pkg;
    // target address: fixed upper bits, lower three from the select straps
    localparam logic [3:0] ADDR_HI = 4'h4;
    // register indices selected by the command byte
    localparam logic [2:0] REG_IN0 = 3'h0;
    localparam logic [2:0] REG_IN1 = 3'h1;
    localparam logic [2:0] OUTPUT_LATCH_LOW = 3'h2;
    localparam logic [2:0] OUTPUT_LATCH_HIGH = 3'h3;
    localparam logic [2:0] REG_POL0 = 3'h4;
    localparam logic [2:0] REG_POL1 = 3'h5;
    localparam logic [2:0] REG_CFG0 = 3'h6;
    localparam logic [2:0] REG_CFG1 = 3'h7;
    // values after reset: all pins inputs, no inversion, latches high
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;
    // controller register map (byte addresses on apb)
    localparam logic [11:0] CMD_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] DIV_OFS = 12'h008;
    // command register fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_NACK_BIT = 10;
    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NACK_BIT = 1;
    localparam int ST_IDLE_BIT = 2;
    localparam int ST_OPEN_BIT = 3;
    localparam int ST_RX_LSB = 8;
    // serial clock timing: quarter period in pclk cycles
    localparam int CLK_KHZ = 10000;
    localparam int SCL_KHZ = 100;
    localparam int QUARTER_CYC = CLK_KHZ / (4 * SCL_KHZ);
    localparam logic [7:0] DIV_RST = 8'(QUARTER_CYC - 1);
    // controller byte-level operations
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} gpx_op_e;
    // device and controller states
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_ACK, D_TX, D_MACK} gpx_dst_e;
    typedef enum logic [1:0] {C_IDLE, C_START, C_STOP, C_BIT} gpx_cst_e;
endpackage

// ===== gpx_i2c_if.sv
`timescale 1ns/1ps
interface gpx_i2c_if;
    logic scl_o; // controller clock output level
    logic scl_oe; // controller pulls clock low
    logic ctl_sda_o; // controller data output level
    logic ctl_sda_oe; // controller pulls data low
    logic dev_sda_o; // device data output level
    logic dev_sda_oe; // device pulls data low
    logic scl; // resolved clock line
    logic sda; // resolved data line
    // open-drain lines with pull-ups: low while any enabled driver drives low
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~(ctl_sda_oe & ~ctl_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
    modport ctl (output scl_o, scl_oe, ctl_sda_o, ctl_sda_oe, input scl, sda);
    modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ===== gpx_dev.sv
// Operation
// - address with rw zero starts a write
// - first written byte selects the register
// - eight byte registers in four pairs
// - write bytes alternate within the pair
// - unlimited write bytes until stop
// - read first writes command byte
// - restart with rw one returns selected register
// - read bytes alternate within the pair
// - controller nacks the last read byte
// - pointer is kept across restart
// - device acknowledges its own address and every byte it receives after it
// - new transfer only on idle bus
// - select pins complete the address
// - inputs latched at acknowledge clock rise
// - power-up: all inputs, pull-ups on
// - reset pin clears state and registers
`timescale 1ns/1ps
module gpx_dev (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic rst_pin_n, // external reset pin, active low
    input wire logic [2:0] addr_sel, // address select straps
    input wire logic [15:0] gpio_in, // pin levels
    output logic [15:0] gpio_out, // pin output levels
    output logic [15:0] gpio_oe, // pin output enables
    output logic [15:0] gpio_pu_en, // pin pull-up enables
    output logic int_n, // interrupt, active low
    gpx_i2c_if.dev bus // serial bus
);
    typedef struct packed {
        gpx_pkg::gpx_dst_e st;
        logic scl_q;
        logic sda_q;
        logic [2:0] cnt;
        logic full;
        logic [7:0] sh;
        logic rd;
        logic cmd_next;
        logic [2:0] ptr;
        logic [7:0][7:0] regs;
        logic sda_oe;
        logic int_n;
        logic [15:0] gpio_out;
        logic [15:0] gpio_oe;
        logic [15:0] gpio_pu;
    } gpx_dev_s;

    // power-up contents of all state
    function automatic gpx_dev_s dev_reset();
        gpx_dev_s s;
        s = '0;
        s.st = gpx_pkg::D_IDLE;
        s.scl_q = 1'b1;
        s.sda_q = 1'b1;
        s.int_n = 1'b1;
        s.regs[gpx_pkg::OUTPUT_LATCH_LOW] = gpx_pkg::OUT_RST;
        s.regs[gpx_pkg::OUTPUT_LATCH_HIGH] = gpx_pkg::OUT_RST;
        s.regs[gpx_pkg::REG_POL0] = gpx_pkg::POL_RST;
        s.regs[gpx_pkg::REG_POL1] = gpx_pkg::POL_RST;
        s.regs[gpx_pkg::REG_CFG0] = gpx_pkg::CFG_RST;
        s.regs[gpx_pkg::REG_CFG1] = gpx_pkg::CFG_RST;
        s.gpio_out = {gpx_pkg::OUT_RST, gpx_pkg::OUT_RST};
        s.gpio_pu = {gpx_pkg::CFG_RST, gpx_pkg::CFG_RST};
        return s;
    endfunction

    localparam gpx_dev_s RST = dev_reset();

    gpx_dev_s r;
    gpx_dev_s n;
    logic [15:0] live;
    logic [15:0] cfg;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    // bus condition detection from the previous line sample
    always_comb
    begin
        scl_rise = bus.scl & ~r.scl_q;
        scl_fall = ~bus.scl & r.scl_q;
        start_c = r.scl_q & bus.scl & r.sda_q & ~bus.sda;
        stop_c = r.scl_q & bus.scl & ~r.sda_q & bus.sda;
        cfg = {r.regs[gpx_pkg::REG_CFG1], r.regs[gpx_pkg::REG_CFG0]};
        live = gpio_in ^ {r.regs[gpx_pkg::REG_POL1], r.regs[gpx_pkg::REG_POL0]};
    end

    // next state: protocol engine and register file
    always_comb
    begin
        n = r;
        n.scl_q = bus.scl;
        n.sda_q = bus.sda;
        if (start_c)
        begin
            // start or repeated start; pointer is kept
            n.st = gpx_pkg::D_ADDR;
            n.cnt = 3'h0;
            n.full = 1'b0;
            n.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            n.st = gpx_pkg::D_IDLE;
            n.sda_oe = 1'b0;
        end
        else
        begin
            // shift in a received bit on each clock rise
            if ((r.st == gpx_pkg::D_ADDR || r.st == gpx_pkg::D_RX) && scl_rise)
            begin
                n.sh = {r.sh[6:0], bus.sda};
                n.cnt = r.cnt + 3'h1;
                n.full = (r.cnt == 3'h7);
            end
            case (r.st)
                gpx_pkg::D_IDLE:
                begin
                    n.sda_oe = 1'b0;
                end
                gpx_pkg::D_ADDR:
                begin
                    if (scl_fall && r.full)
                    begin
                        n.full = 1'b0;
                        if (r.sh[7:1] == {gpx_pkg::ADDR_HI, addr_sel})
                        begin
                            n.st = gpx_pkg::D_ACK;
                            n.sda_oe = 1'b1;
                            n.rd = r.sh[0];
                            n.cmd_next = ~r.sh[0];
                        end
                        else
                        begin
                            n.st = gpx_pkg::D_IDLE;
                        end
                    end
                end
                gpx_pkg::D_RX:
                begin
                    if (scl_fall && r.full)
                    begin
                        n.full = 1'b0;
                        n.st = gpx_pkg::D_ACK;
                        n.sda_oe = 1'b1;
                        if (r.cmd_next)
                        begin
                            n.ptr = r.sh[2:0];
                            n.cmd_next = 1'b0;
                        end
                        else
                        begin
                            // input port registers ignore writes
                            if (r.ptr[2:1] != 2'b00)
                            begin
                                n.regs[r.ptr] = r.sh;
                            end
                            n.ptr = r.ptr ^ 3'h1;
                        end
                    end
                end
                gpx_pkg::D_ACK:
                begin
                    if (scl_rise && r.rd)
                    begin
                        n.regs[gpx_pkg::REG_IN0] = live[7:0];
                        n.regs[gpx_pkg::REG_IN1] = live[15:8];
                    end
                    if (scl_fall)
                    begin
                        n.cnt = 3'h0;
                        if (r.rd)
                        begin
                            n.st = gpx_pkg::D_TX;
                            n.sh = n.regs[r.ptr];
                            n.sda_oe = ~n.sh[7];
                        end
                        else
                        begin
                            n.st = gpx_pkg::D_RX;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                gpx_pkg::D_TX:
                begin
                    if (scl_fall)
                    begin
                        if (r.cnt == 3'h7)
                        begin
                            n.sda_oe = 1'b0;
                            n.st = gpx_pkg::D_MACK;
                            n.ptr = r.ptr ^ 3'h1;
                        end
                        else
                        begin
                            n.cnt = r.cnt + 3'h1;
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                gpx_pkg::D_MACK:
                begin
                    if (scl_rise)
                    begin
                        if (bus.sda)
                        begin
                            n.st = gpx_pkg::D_IDLE;
                        end
                        else
                        begin
                            n.regs[gpx_pkg::REG_IN0] = live[7:0];
                            n.regs[gpx_pkg::REG_IN1] = live[15:8];
                        end
                    end
                    if (scl_fall)
                    begin
                        n.st = gpx_pkg::D_TX;
                        n.cnt = 3'h0;
                        n.sh = r.regs[r.ptr];
                        n.sda_oe = ~r.regs[r.ptr][7];
                    end
                end
                default:
                begin
                    n.st = gpx_pkg::D_IDLE;
                end
            endcase
        end
        // pin drivers follow the register file
        n.gpio_oe = ~{n.regs[gpx_pkg::REG_CFG1], n.regs[gpx_pkg::REG_CFG0]};
        n.gpio_out = {n.regs[gpx_pkg::OUTPUT_LATCH_HIGH], n.regs[gpx_pkg::OUTPUT_LATCH_LOW]};
        n.gpio_pu = {n.regs[gpx_pkg::REG_CFG1], n.regs[gpx_pkg::REG_CFG0]};
        // change on an input pin against the last latched reading
        n.int_n = ((live & cfg) == ({n.regs[1], n.regs[0]} & cfg));
        if (!rst_pin_n)
        begin
            n = RST;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= RST;
        end
        else
        begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign gpio_out = r.gpio_out;
    assign gpio_oe = r.gpio_oe;
    assign gpio_pu_en = r.gpio_pu;
    assign int_n = r.int_n;
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = r.sda_oe;
endmodule // gpx_dev

// ===== gpx_ctl.sv
`timescale 1ns/1ps
module gpx_ctl (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, always low
    gpx_i2c_if.ctl bus // serial bus
);
    typedef struct packed {
        gpx_pkg::gpx_cst_e st;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] dcnt;
        logic [7:0] qdiv;
        logic [8:0] sh;
        logic [7:0] rx;
        logic nack;
        logic open;
        logic scl_lo;
        logic sda_lo;
        logic [31:0] prdata;
        logic pready;
    } gpx_ctl_s;

    localparam gpx_ctl_s RST = '{
        st: gpx_pkg::C_IDLE, qdiv: gpx_pkg::DIV_RST, dcnt: gpx_pkg::DIV_RST, default: '0};

    gpx_ctl_s r;
    gpx_ctl_s n;
    logic tick;
    logic wr_en;
    logic [1:0] op;

    // next state: apb slave, clock divider and bit sequencer
    always_comb
    begin
        n = r;
        tick = 1'b0;
        wr_en = psel & penable & r.pready & pwrite;
        op = pwdata[gpx_pkg::CMD_OP_LSB +: 2];
        // zero-wait apb: ready in the first access cycle
        n.pready = psel & ~penable;
        n.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                gpx_pkg::STAT_OFS:
                begin
                    n.prdata[gpx_pkg::ST_BUSY_BIT] = (r.st != gpx_pkg::C_IDLE);
                    n.prdata[gpx_pkg::ST_NACK_BIT] = r.nack;
                    n.prdata[gpx_pkg::ST_IDLE_BIT] = bus.scl & bus.sda;
                    n.prdata[gpx_pkg::ST_OPEN_BIT] = r.open;
                    n.prdata[gpx_pkg::ST_RX_LSB +: 8] = r.rx;
                end
                gpx_pkg::DIV_OFS:
                begin
                    n.prdata[7:0] = r.qdiv;
                end
                default:
                begin
                    n.prdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr_en && paddr == gpx_pkg::DIV_OFS && r.st == gpx_pkg::C_IDLE)
        begin
            n.qdiv = pwdata[7:0];
        end
        // commands are taken only while idle
        if (wr_en && paddr == gpx_pkg::CMD_OFS && r.st == gpx_pkg::C_IDLE)
        begin
            n.ph = 2'h0;
            n.bitn = 4'h0;
            n.dcnt = r.qdiv;
            case (op)
                gpx_pkg::OP_START:
                begin
                    // a fresh start is taken only on released lines, otherwise the command is dropped
                    if (r.open || (bus.scl && bus.sda))
                    begin
                        n.st = gpx_pkg::C_START;
                    end
                end
                gpx_pkg::OP_STOP:
                begin
                    n.st = gpx_pkg::C_STOP;
                end
                gpx_pkg::OP_WRITE:
                begin
                    // address byte carries rw in bit 0, then command byte
                    n.sh = {pwdata[gpx_pkg::CMD_DATA_LSB +: 8], 1'b1};
                    n.st = gpx_pkg::C_BIT;
                end
                gpx_pkg::OP_READ:
                begin
                    n.sh = {8'hff, pwdata[gpx_pkg::CMD_NACK_BIT]};
                    n.st = gpx_pkg::C_BIT;
                end
                default:
                begin
                    n.st = gpx_pkg::C_IDLE;
                end
            endcase
        end
        else if (r.st != gpx_pkg::C_IDLE)
        begin
            // quarter-period enable pulse
            if (r.dcnt == 8'h00)
            begin
                tick = 1'b1;
                n.dcnt = r.qdiv;
            end
            else
            begin
                n.dcnt = r.dcnt - 8'h01;
            end
        end
        if (tick)
        begin
            n.ph = r.ph + 2'h1;
            case (r.st)
                gpx_pkg::C_START:
                begin
                    // start and repeated start: high data, clock high, data falls
                    case (r.ph)
                        2'h0:
                        begin
                            n.scl_lo = 1'b1;
                            n.sda_lo = 1'b0;
                        end
                        2'h1: n.scl_lo = 1'b0;
                        2'h2: n.sda_lo = 1'b1;
                        default:
                        begin
                            n.scl_lo = 1'b1;
                            n.open = 1'b1;
                            n.st = gpx_pkg::C_IDLE;
                        end
                    endcase
                end
                gpx_pkg::C_STOP:
                begin
                    // low data, clock high, data rises: bus released
                    case (r.ph)
                        2'h0:
                        begin
                            n.scl_lo = 1'b1;
                            n.sda_lo = 1'b1;
                        end
                        2'h1: n.scl_lo = 1'b0;
                        2'h2: n.sda_lo = 1'b0;
                        default:
                        begin
                            n.open = 1'b0;
                            n.st = gpx_pkg::C_IDLE;
                        end
                    endcase
                end
                gpx_pkg::C_BIT:
                begin
                    // eight data bits then the acknowledge bit
                    case (r.ph)
                        2'h0:
                        begin
                            n.scl_lo = 1'b1;
                            n.sda_lo = ~r.sh[8];
                        end
                        2'h1: n.scl_lo = 1'b0;
                        2'h2: n.sh = {r.sh[7:0], bus.sda};
                        default:
                        begin
                            n.scl_lo = 1'b1;
                            n.bitn = r.bitn + 4'h1;
                            if (r.bitn == 4'h8)
                            begin
                                n.rx = r.sh[8:1];
                                n.nack = r.sh[0];
                                n.sda_lo = 1'b0;
                                n.st = gpx_pkg::C_IDLE;
                            end
                        end
                    endcase
                end
                default:
                begin
                    n.st = gpx_pkg::C_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= RST;
        end
        else
        begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = 1'b0;
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = r.scl_lo;
    assign bus.ctl_sda_o = 1'b0;
    assign bus.ctl_sda_oe = r.sda_lo;
endmodule // gpx_ctl

// ===== gpx_monitor.sv
`timescale 1ns/1ps
module gpx_monitor (
    input wire logic pclk, // system clock
    input wire logic presetn, // reset, active low
    input wire logic scl_o, // controller clock level
    input wire logic scl_oe, // controller clock pull
    input wire logic ctl_sda_o, // controller data level
    input wire logic ctl_sda_oe, // controller data pull
    input wire logic dev_sda_o, // device data level
    input wire logic dev_sda_oe, // device data pull
    input wire logic scl, // resolved clock line
    input wire logic sda // resolved data line
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // clock phases of the serial bit
    sequence s_high;
        scl [*3];
    endsequence
    sequence s_low;
        !scl [*2];
    endsequence
    sequence s_hold;
        scl [*2];
    endsequence
    // open drain: nobody drives a high level
    a_open_drain: assert property (!scl_o && !ctl_sda_o && !dev_sda_o)
        else $error("bus line driven high");
    // at most one end pulls data while the clock is high
    a_one_driver: assert property (scl |-> !(dev_sda_oe && ctl_sda_oe))
        else $error("both ends pull data");
    // device moves data only just after a clock fall
    a_dev_edge_align: assert property ($changed(dev_sda_oe)
        |-> !scl && ($past(scl) || $past(scl, 2) || $past(scl, 3)))
        else $error("device data moved away from clock fall");
    a_high_phase: assert property ($rose(scl) |-> s_high)
        else $error("clock high phase too short");
    a_low_phase: assert property ($fell(scl) |-> s_low)
        else $error("clock low phase too short");
    // start holds the clock high after data falls
    a_start_hold: assert property (scl && $rose(ctl_sda_oe) |-> s_hold)
        else $error("start condition cut short");
    // after a stop the clock stays high
    a_stop_hold: assert property (scl && $fell(ctl_sda_oe) |=> s_high)
        else $error("clock fell right after stop");
    // device releases the line once the transfer is closed
    a_quiet_after_stop: assert property (scl && $past(scl) && $rose(sda)
        |=> !dev_sda_oe [*8])
        else $error("device drives data after stop");
endmodule // gpx_monitor

// ===== test_i2c_gpio_register_pair_access.sv
`timescale 1ns/1ps
module test_i2c_gpio_register_pair_access;
    logic pclk, presetn, rst_pin_n, psel, penable, pwrite, int_n, pready, pslverr;
    logic [2:0] addr_sel;
    logic [15:0] gpio_in, gpio_out, gpio_oe, gpio_pu_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_count, cmp_count, cyc;
    gpx_i2c_if gpx_i2c_if_i ();
    gpx_dev gpx_dev_i (.pclk(pclk), .presetn(presetn), .rst_pin_n(rst_pin_n),
        .addr_sel(addr_sel), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_pu_en(gpio_pu_en), .int_n(int_n), .bus(gpx_i2c_if_i));
    gpx_ctl gpx_ctl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(gpx_i2c_if_i));
    gpx_monitor gpx_monitor_i (.pclk(pclk), .presetn(presetn), .scl_o(gpx_i2c_if_i.scl_o),
        .scl_oe(gpx_i2c_if_i.scl_oe), .ctl_sda_o(gpx_i2c_if_i.ctl_sda_o),
        .ctl_sda_oe(gpx_i2c_if_i.ctl_sda_oe), .dev_sda_o(gpx_i2c_if_i.dev_sda_o),
        .dev_sda_oe(gpx_i2c_if_i.dev_sda_oe), .scl(gpx_i2c_if_i.scl), .sda(gpx_i2c_if_i.sda));
    // clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_sim;
        end
    end
    // compare one value
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        chk("pslverr", pslverr, 32'h0000_0000);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one byte-level operation, waits until not busy
    task xfer(input logic [1:0] op, input logic [7:0] b, input logic nk, output logic [31:0] s);
        apb(1'b1, gpx_pkg::CMD_OFS, 32'({nk, op, b}), s);
        s = 32'h0000_0001;
        while (s[gpx_pkg::ST_BUSY_BIT] !== 1'b0)
            apb(1'b0, gpx_pkg::STAT_OFS, 32'h0000_0000, s);
    endtask
    // start or restart, then address byte
    task adr(input logic [2:0] a, input logic rw, output logic [31:0] s);
        xfer(gpx_pkg::OP_START, 8'h00, 1'b0, s);
        xfer(gpx_pkg::OP_WRITE, {gpx_pkg::ADDR_HI, a, rw}, 1'b0, s);
    endtask
    // command byte and data bytes, closed by stop
    task wr(input logic [7:0] c, input logic [7:0] d[$]);
        logic [31:0] s;
        adr(addr_sel, 1'b0, s);
        chk("address ack", s[gpx_pkg::ST_NACK_BIT], 32'h0000_0000);
        xfer(gpx_pkg::OP_WRITE, c, 1'b0, s);
        foreach (d[i])
        begin
            xfer(gpx_pkg::OP_WRITE, d[i], 1'b0, s);
            chk("data ack", s[gpx_pkg::ST_NACK_BIT], 32'h0000_0000);
        end
        xfer(gpx_pkg::OP_STOP, 8'h00, 1'b0, s);
    endtask
    // restart for reading, last byte not acknowledged
    task rd(input logic [7:0] e[$]);
        logic [31:0] s;
        adr(addr_sel, 1'b1, s);
        chk("read address ack", s[gpx_pkg::ST_NACK_BIT], 32'h0000_0000);
        foreach (e[i])
        begin
            xfer(gpx_pkg::OP_READ, 8'h00, 1'(i == e.size() - 1), s);
            chk("read byte", s[gpx_pkg::ST_RX_LSB +: 8], e[i]);
        end
    endtask
    // power-up state and controller registers
    task t_reset;
        logic [31:0] r;
        chk("gpio_out", gpio_out, 32'h0000_ffff);
        chk("gpio_oe", gpio_oe, 32'h0000_0000);
        chk("gpio_pu_en", gpio_pu_en, 32'h0000_ffff);
        apb(1'b0, gpx_pkg::DIV_OFS, 32'h0000_0000, r);
        chk("divider", r, 32'(gpx_pkg::DIV_RST));
        apb(1'b0, gpx_pkg::STAT_OFS, 32'h0000_0000, r);
        chk("bus idle", r[gpx_pkg::ST_IDLE_BIT], 32'h0000_0001);
        apb(1'b0, 12'h040, 32'h0000_0000, r);
        chk("unmapped read", r, 32'h0000_0000);
        apb(1'b1, gpx_pkg::DIV_OFS, 32'h0000_0001, r);
        $display("test reset done");
    endtask
    // writes alternate within the output pair
    task t_write;
        wr(8'(gpx_pkg::OUTPUT_LATCH_LOW), '{8'h12, 8'h34, 8'h56});
        chk("output pair", gpio_out, 32'h0000_3456);
        wr(8'(gpx_pkg::OUTPUT_LATCH_HIGH), '{8'hab, 8'hcd});
        chk("output from high", gpio_out, 32'h0000_abcd);
        $display("test write done");
    endtask
    // reads alternate, pointer survives restart, inversion, interrupt
    task t_read;
        logic [31:0] s;
        gpio_in <= 16'ha55a;
        wr(8'(gpx_pkg::REG_POL0), '{8'h0f});
        chk("interrupt raised", int_n, 32'h0000_0000);
        adr(addr_sel, 1'b0, s);
        xfer(gpx_pkg::OP_WRITE, 8'(gpx_pkg::REG_IN1), 1'b0, s);
        rd('{8'ha5, 8'h55});
        rd('{8'ha5});
        xfer(gpx_pkg::OP_STOP, 8'h00, 1'b0, s);
        chk("interrupt cleared", int_n, 32'h0000_0001);
        $display("test read done");
    endtask
    // straps complete the address
    task t_addr;
        logic [31:0] s;
        adr(3'h5, 1'b0, s);
        chk("foreign address", s[gpx_pkg::ST_NACK_BIT], 32'h0000_0001);
        chk("transfer open", s[gpx_pkg::ST_OPEN_BIT], 32'h0000_0001);
        xfer(gpx_pkg::OP_STOP, 8'h00, 1'b0, s);
        chk("transfer closed", s[gpx_pkg::ST_OPEN_BIT], 32'h0000_0000);
        // let the new strap land before the address byte is built from it
        addr_sel <= 3'h5;
        @(posedge pclk);
        wr(8'(gpx_pkg::OUTPUT_LATCH_LOW), '{8'h0f});
        chk("strapped address", gpio_out, 32'h0000_ab0f);
        $display("test address done");
    endtask
    // configuration drives pins, then the reset pin clears it
    task t_cfg;
        wr(8'(gpx_pkg::REG_CFG0), '{8'h00, 8'h0f});
        chk("gpio_oe", gpio_oe, 32'h0000_f0ff);
        chk("gpio_pu_en", gpio_pu_en, 32'h0000_0f00);
        rst_pin_n <= 1'b0;
        @(posedge pclk);
        rst_pin_n <= 1'b1;
        @(posedge pclk);
        chk("gpio_out after pin", gpio_out, 32'h0000_ffff);
        chk("gpio_oe after pin", gpio_oe, 32'h0000_0000);
        $display("test config done");
    endtask
    // counts and verdict
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // reset, then the scenarios
    initial
    begin
        presetn = 1'b0;
        rst_pin_n = 1'b1;
        addr_sel = 3'h0;
        gpio_in = 16'h0000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_write;
        t_read;
        t_addr;
        t_cfg;
        end_sim;
    end
endmodule // test_i2c_gpio_register_pair_access
